/* File: verilog/eied_ext_irq.sv */
// External interrupt control: clock gates, input 1 filter, edge detect and AXI4-Lite registers
//
// Functional notes
// - Cleared enable bit stops input circuit entirely
// - Config writes ignored while input disabled
// - Clock gate bits 7 and 6 read zero
// - Level flag captures filtered level at request
// - Edge select: rising, falling or both
// - High speed sampling gear, /4, /8, /16
// - Low speed sampling at low clock /4
// - Config bits 7 to 5 read zero
// - Software disables interrupt before config write
// - Software disables interrupt before gate change
// - Latch holds until accepted or cleared
// - Inputs pass noise canceller before detection
`timescale 1ns/1ns
`include "eied_cfg.svh"

module eied_ext_irq
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`EIED_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`EIED_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq1_pin,
  input wire logic cpu_irq_accept,
  output logic [5:0] per_input_clock_enable,
  output logic irq1_latch,
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0] clock_gate_r;
  logic [1:0] edge_select_r;
  logic [1:0] filter_sample_rate_select_r;
  logic captured_filtered_level_r;
  logic status_r;
  logic mask_r;
  logic low_speed_r;
  logic en1;

  assign en1 = clock_gate_r[`EIED_GATE_IN1];
  assign per_input_clock_enable = clock_gate_r;

  function automatic logic addr_is(input logic [`EIED_ADDR_W-1:0] a, input logic [15:0] idx);
    addr_is = (a == `EIED_BYTE_ADDR(idx));
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [`EIED_ADDR_W-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic wr_go;
  logic wr_ok;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_ok = addr_is(awaddr_r, `EIED_IDX_CLOCK_GATE) || addr_is(awaddr_r, `EIED_IDX_IRQ1_CONFIG) ||
    addr_is(awaddr_r, `EIED_IDX_IRQ_STATUS) || addr_is(awaddr_r, `EIED_IDX_IRQ_MASK) ||
    addr_is(awaddr_r, `EIED_IDX_MODE);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      w_held_r <= 1'b0;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata[7:0];
      wlane_r <= s_axi_wstrb[0];
    end
    else if (wr_go)
      w_held_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic wr_en;
  assign wr_en = wr_go && wlane_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      clock_gate_r <= `EIED_RST_CLOCK_GATE;
    else if (wr_en && addr_is(awaddr_r, `EIED_IDX_CLOCK_GATE))
      clock_gate_r <= wdata_r[5:0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      {edge_select_r, filter_sample_rate_select_r} <= `EIED_RST_IRQ1_CONFIG;
    else if (wr_en && en1 && addr_is(awaddr_r, `EIED_IDX_IRQ1_CONFIG))
      {edge_select_r, filter_sample_rate_select_r} <= wdata_r[`EIED_CFG_ES_HI:`EIED_CFG_NC_LO];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_r <= `EIED_RST_IRQ_MASK;
      low_speed_r <= 1'b0;
    end
    else if (wr_en && addr_is(awaddr_r, `EIED_IDX_IRQ_MASK))
      mask_r <= wdata_r[`EIED_STAT_IN1];
    else if (wr_en && addr_is(awaddr_r, `EIED_IDX_MODE))
      low_speed_r <= wdata_r[`EIED_MODE_LOW_SPEED];
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic rd_take;
  logic rd_stat;
  eied_pkg::eied_rsel_t rsel_r;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_stat = rd_take && addr_is(s_axi_araddr, `EIED_IDX_IRQ_STATUS);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      rsel_r <= eied_pkg::EIED_RSEL_NONE;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      rsel_r <= eied_pkg::EIED_RSEL_OTHER;
      if (addr_is(s_axi_araddr, `EIED_IDX_CLOCK_GATE))
      begin
        s_axi_rdata <= {26'h0, clock_gate_r};
        rsel_r <= eied_pkg::EIED_RSEL_GATE;
      end
      else if (addr_is(s_axi_araddr, `EIED_IDX_IRQ1_CONFIG))
        s_axi_rdata <= {27'h0, captured_filtered_level_r, edge_select_r, filter_sample_rate_select_r};
      else if (rd_stat)
        s_axi_rdata <= {31'h0, status_r};
      else if (addr_is(s_axi_araddr, `EIED_IDX_IRQ_MASK))
        s_axi_rdata <= {31'h0, mask_r};
      else if (addr_is(s_axi_araddr, `EIED_IDX_MODE))
        s_axi_rdata <= {31'h0, low_speed_r};
      else
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'h2;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Sampling rate
  // ----------------------------------------------------------------
  // Gear clock is clk itself; the low clock is a divided enable
  logic [3:0] gear_cnt_r;
  logic [15:0] lf_cnt_r;
  logic [1:0] lf_quarter_r;
  logic lf_tick;
  logic lf_q_tick;
  logic sample_en;

  function automatic logic rate_tick(input logic [1:0] sel, input logic [3:0] cnt);
    case (eied_pkg::eied_rate_t'(sel))
      eied_pkg::EIED_NC_DIV1: rate_tick = 1'b1;
      eied_pkg::EIED_NC_DIV4: rate_tick = (cnt[1:0] == 2'h3);
      eied_pkg::EIED_NC_DIV8: rate_tick = (cnt[2:0] == 3'h7);
      default: rate_tick = (cnt == 4'hf);
    endcase
  endfunction

  assign lf_tick = (lf_cnt_r == 16'(`EIED_LF_DIV - 1));
  assign lf_q_tick = lf_tick && (lf_quarter_r == 2'(`EIED_LF_QUARTER - 1));

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      gear_cnt_r <= 4'h0;
    else
      gear_cnt_r <= gear_cnt_r + 4'h1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lf_cnt_r <= 16'h0;
      lf_quarter_r <= 2'h0;
    end
    else if (lf_tick)
    begin
      lf_cnt_r <= 16'h0;
      lf_quarter_r <= lf_quarter_r + 2'h1;
    end
    else
      lf_cnt_r <= lf_cnt_r + 16'h1;
  end

  // Gated clock modelled as a gated enable: disabled circuit freezes
  assign sample_en = en1 && (low_speed_r ? lf_q_tick :
    rate_tick(filter_sample_rate_select_r, gear_cnt_r));

  // ----------------------------------------------------------------
  // Filter and edge detection
  // ----------------------------------------------------------------
  logic pin_meta_r;
  logic pin_sync_r;
  logic filt;
  logic prev_r;
  logic req;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= ext_irq1_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  eied_noise_filter u_filter
  (
    .clk(clk),
    .reset_n(reset_n),
    .sample_en(sample_en),
    .pin_level(pin_sync_r),
    .filtered(filt)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prev_r <= 1'b0;
    else
      prev_r <= filt;
  end

  always_comb
  begin
    req = 1'b0;
    if (en1)
    begin
      case (eied_pkg::eied_edge_t'(edge_select_r))
        eied_pkg::EIED_ES_RISE: req = filt && !prev_r;
        eied_pkg::EIED_ES_FALL: req = !filt && prev_r;
        eied_pkg::EIED_ES_BOTH: req = filt != prev_r;
        default: req = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      captured_filtered_level_r <= 1'b0;
    else if (req)
      captured_filtered_level_r <= filt;
  end

  // ----------------------------------------------------------------
  // Latch, status and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq1_latch <= 1'b0;
    else if (req)
      irq1_latch <= 1'b1;
    else if (cpu_irq_accept)
      irq1_latch <= 1'b0;
  end

  // A new event beats a clearing read in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      status_r <= 1'b0;
    else if (req)
      status_r <= 1'b1;
    else if (rd_stat)
      status_r <= 1'b0;
  end

  assign irq = status_r && mask_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_OFF_NO_REQ: assert property (@(posedge clk) disable iff (!reset_n) !en1 |-> !req && !sample_en)
    else $error("Disabled input produced activity");
  AST_CFG_FROZEN: assert property (@(posedge clk) disable iff (!reset_n)
    !en1 |=> $stable(edge_select_r) && $stable(filter_sample_rate_select_r))
    else $error("Config changed while input disabled");
  AST_GATE_TOP_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    s_axi_rvalid && rsel_r == eied_pkg::EIED_RSEL_GATE |-> s_axi_rdata[7:6] == 2'h0)
    else $error("Clock gate top bits not zero");
  AST_LEVEL_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n)
    req |=> captured_filtered_level_r == $past(filt))
    else $error("Level flag missed the filtered level");
  AST_RISE_REQ: assert property (@(posedge clk) disable iff (!reset_n)
    en1 && edge_select_r == 2'h0 && filt && !prev_r |-> req ##1 irq1_latch)
    else $error("Rising edge gave no request");
  AST_HS_RATE: assert property (@(posedge clk) disable iff (!reset_n)
    sample_en && !low_speed_r && filter_sample_rate_select_r == 2'h3 |-> gear_cnt_r == 4'hf)
    else $error("Gear /16 sampling off");
  AST_LS_RATE: assert property (@(posedge clk) disable iff (!reset_n)
    sample_en && low_speed_r |-> lf_tick && lf_quarter_r == 2'h3)
    else $error("Low speed sampling not at low clock /4");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    irq1_latch && !cpu_irq_accept |=> irq1_latch)
    else $error("Latch dropped without acceptance");
  AST_RSVD_SILENT: assert property (@(posedge clk) disable iff (!reset_n)
    edge_select_r == 2'h3 |-> !req)
    else $error("Reserved edge code made a request");
  AST_REQ_FROM_FILTER: assert property (@(posedge clk) disable iff (!reset_n)
    req |-> filt != prev_r)
    else $error("Request without a filtered change");

endmodule // eied_ext_irq

/* File: verilog/eied_cfg.svh */
// Address map, field positions, reset values and timing counts of the external interrupt block
`ifndef EIED_CFG_SVH
`define EIED_CFG_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define EIED_IDX_CLOCK_GATE 16'h0f77
`define EIED_IDX_IRQ1_CONFIG 16'h0fd8
`define EIED_IDX_IRQ_STATUS 16'h0f80
`define EIED_IDX_IRQ_MASK 16'h0f81
`define EIED_IDX_MODE 16'h0f82
`define EIED_BYTE_ADDR(idx) ({(idx), 2'b00})
`define EIED_ADDR_W 18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EIED_GATE_IN1 1
`define EIED_CFG_LVL 4
`define EIED_CFG_ES_HI 3
`define EIED_CFG_ES_LO 2
`define EIED_CFG_NC_HI 1
`define EIED_CFG_NC_LO 0
`define EIED_STAT_IN1 0
`define EIED_MODE_LOW_SPEED 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EIED_RST_CLOCK_GATE 6'h00
`define EIED_RST_IRQ1_CONFIG 4'h0
`define EIED_RST_IRQ_MASK 1'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EIED_CLK_HZ 50000000
`define EIED_LF_HZ 32768
`define EIED_LF_DIV (`EIED_CLK_HZ / `EIED_LF_HZ)
`define EIED_LF_QUARTER 4
`define EIED_NF_SAMPLES 3

`endif

/* File: verilog/eied_pkg.sv */
// Types shared by the external interrupt block
package eied_pkg;

  typedef enum logic [1:0] {
    EIED_ES_RISE = 2'h0,
    EIED_ES_FALL = 2'h1,
    EIED_ES_BOTH = 2'h2,
    EIED_ES_RSVD = 2'h3
  } eied_edge_t;

  typedef enum logic [1:0] {
    EIED_NC_DIV1 = 2'h0,
    EIED_NC_DIV4 = 2'h1,
    EIED_NC_DIV8 = 2'h2,
    EIED_NC_DIV16 = 2'h3
  } eied_rate_t;

  typedef enum logic [2:0] {
    EIED_RSEL_NONE = 3'h1,
    EIED_RSEL_GATE = 3'h2,
    EIED_RSEL_OTHER = 3'h4
  } eied_rsel_t;

endpackage

/* File: verilog/eied_noise_filter.sv */
// Sampling noise canceller: new level accepted after equal consecutive samples
`timescale 1ns/1ns
`include "eied_cfg.svh"

module eied_noise_filter
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample_en,
  input wire logic pin_level,
  output logic filtered
);

  logic [1:0] agree_r;

  // ----------------------------------------------------------------
  // Agreement counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      agree_r <= 2'h0;
    else if (sample_en)
    begin
      if (pin_level == filtered)
        agree_r <= 2'h0;
      else if (agree_r == 2'(`EIED_NF_SAMPLES - 1))
        agree_r <= 2'h0;
      else
        agree_r <= agree_r + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      filtered <= 1'b0;
    else if (sample_en && pin_level != filtered && agree_r == 2'(`EIED_NF_SAMPLES - 1))
      filtered <= pin_level;
  end

  AST_FILTER_AGREE: assert property (@(posedge clk) disable iff (!reset_n)
    (filtered != $past(filtered)) |-> ($past(sample_en) && $past(agree_r) == 2'h2))
    else $error("Filter output changed before enough equal samples");

endmodule // eied_noise_filter

/* File: testbench/eied_pin_model.sv */
// Far-side model: interrupt pin source and CPU interrupt acceptance
`timescale 1ns/1ns

module eied_pin_model
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic level_cmd,
  input wire logic accept_cmd,
  input wire logic irq1_latch,
  output logic ext_irq1_pin,
  output logic cpu_irq_accept
);
  // ----------------------------------------------------------------
  // Pin level and acceptance
  // ----------------------------------------------------------------
  // Registered, so pin edges always land just after a clock edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_irq1_pin <= 1'b0;
      cpu_irq_accept <= 1'b0;
    end
    else
    begin
      ext_irq1_pin <= level_cmd;
      // A real CPU only accepts a pending latch
      cpu_irq_accept <= accept_cmd && irq1_latch;
    end
  end
endmodule // eied_pin_model

/* File: testbench/tb_top.sv */
// Self-checking bench of the external interrupt block
`timescale 1ns/1ns
`include "eied_cfg.svh"

module tb_top;
  localparam logic [17:0] A_GATE = `EIED_BYTE_ADDR(`EIED_IDX_CLOCK_GATE);
  localparam logic [17:0] A_CFG = `EIED_BYTE_ADDR(`EIED_IDX_IRQ1_CONFIG);
  localparam logic [17:0] A_STAT = `EIED_BYTE_ADDR(`EIED_IDX_IRQ_STATUS);
  localparam logic [17:0] A_MASK = `EIED_BYTE_ADDR(`EIED_IDX_IRQ_MASK);
  localparam logic [17:0] A_MODE = `EIED_BYTE_ADDR(`EIED_IDX_MODE);
  localparam int LF = `EIED_LF_DIV;
  typedef struct {logic [17:0] a; logic [7:0] wd; logic [31:0] rd; logic [1:0] resp;} eied_row_t;
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rr;
  logic pin_cmd, acc_cmd, ext_irq1_pin, cpu_irq_accept, irq1_latch, irq;
  logic [5:0] clk_en;
  logic [3:0] wstrb;
  int num_errors, tests_run;
  int divs [4] = '{1, 4, 8, 16};
  eied_row_t rows [7] = '{'{A_GATE, 8'h00, 32'h0, 2'h0}, '{A_CFG, 8'h0a, 32'h0, 2'h0},
    '{A_GATE, 8'hff, 32'h3f, 2'h0}, '{A_CFG, 8'hff, 32'h0f, 2'h0}, '{A_MASK, 8'h01, 32'h1, 2'h0},
    '{A_MODE, 8'h00, 32'h0, 2'h0}, '{18'h3ffc, 8'h55, 32'h0, 2'h2}};

  eied_ext_irq dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_irq1_pin(ext_irq1_pin),
    .cpu_irq_accept(cpu_irq_accept), .per_input_clock_enable(clk_en), .irq1_latch(irq1_latch), .irq(irq));
  eied_pin_model partner (.clk(clk), .reset_n(reset_n), .level_cmd(pin_cmd), .accept_cmd(acc_cmd),
    .irq1_latch(irq1_latch), .ext_irq1_pin(ext_irq1_pin), .cpu_irq_accept(cpu_irq_accept));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Handshakes are sampled at the falling edge, as ready only moves on rising edges
  task automatic axi_wr(input logic [17:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic ka, kw, kb;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    kb = 1'b0;
    while (!kb && n < 100)
    begin
      @(negedge clk);
      ka = awvalid && awready;
      kw = wvalid && wready;
      kb = bvalid;
      r = bresp;
      @(posedge clk);
      awvalid <= awvalid && !ka;
      wvalid <= wvalid && !kw;
      n++;
    end
    bready <= 1'b0;
    check(32'(kb), 32'h1, "write answer");
  endtask

  task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ka, kr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    kr = 1'b0;
    while (!kr && n < 100)
    begin
      @(negedge clk);
      ka = arvalid && arready;
      kr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      arvalid <= arvalid && !ka;
      n++;
    end
    rready <= 1'b0;
    check(32'(kr), 32'h1, "read answer");
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    axi_wr(a, d, rr);
  endtask

  task automatic rdchk(input logic [17:0] a, input logic [31:0] exp, input string what);
    axi_rd(a, rd, rr);
    check(rd, exp, what);
  endtask

  task automatic pin(input logic v, input int hold);
    @(posedge clk);
    pin_cmd <= v;
    repeat (hold) @(posedge clk);
  endtask

  task automatic accept();
    @(posedge clk);
    acc_cmd <= 1'b1;
    @(posedge clk);
    acc_cmd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Interrupt held off while the config changes, then stale requests flushed
  task automatic arm(input logic [7:0] cfg, input logic [7:0] m);
    wr(A_MASK, 8'h00);
    wr(A_CFG, cfg);
    axi_rd(A_STAT, rd, rr);
    accept();
    wr(A_MASK, m);
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Run needs about 65k cycles; 100k means a hang
  initial
  begin
    #2000000;
    num_errors++;
    final_report();
  end

  initial
  begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, pin_cmd, acc_cmd} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    num_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    check(32'({clk_en, irq1_latch, irq}), 32'h0, "outputs after reset");
    foreach (rows[i]) rdchk(rows[i].a, 32'h0, "reset value");
    $display("test reset done");
    foreach (rows[i])
    begin
      axi_wr(rows[i].a, rows[i].wd, rr);
      check(32'(rr), 32'(rows[i].resp), "write response");
      axi_rd(rows[i].a, rd, rr);
      check(rd, rows[i].rd, "register readback");
      check(32'(rr), 32'(rows[i].resp), "read response");
    end
    $display("test registers done");
    for (int es = 0; es < 4; es++)
    begin
      arm({4'h0, es[1:0], 2'h0}, 8'h01);
      pin(1'b1, 20);
      check(32'(irq1_latch), 32'(es == 0 || es == 2), "latch on rise");
      check(32'(irq), 32'(es == 0 || es == 2), "irq on rise");
      accept();
      check(32'(irq1_latch), 32'h0, "latch after accept");
      pin(1'b0, 20);
      check(32'(irq1_latch), 32'(es == 1 || es == 2), "latch on fall");
      rdchk(A_CFG, {27'h0, es == 0, es[1:0], 2'h0}, "captured level");
    end
    $display("test edge select done");
    for (int nc = 0; nc < 4; nc++)
    begin
      arm({6'h0, nc[1:0]}, 8'h00);
      pin(1'b1, 2 * divs[nc] - 1);
      pin(1'b0, 8 * divs[nc] + 20);
      check(32'(irq1_latch), 32'h0, "short pulse filtered");
      pin(1'b1, 4 * divs[nc]);
      pin(1'b0, 8 * divs[nc] + 20);
      check(32'(irq1_latch), 32'h1, "long pulse passes");
      check(32'(irq), 32'h0, "masked irq");
      rdchk(A_STAT, 32'h1, "status set");
      rdchk(A_STAT, 32'h0, "status cleared by read");
    end
    $display("test sample rate done");
    arm(8'h00, 8'h00);
    wr(A_MODE, 8'h01);
    repeat (12 * LF) @(posedge clk);
    axi_rd(A_STAT, rd, rr);
    accept();
    pin(1'b1, 64);
    pin(1'b0, 100);
    check(32'(irq1_latch), 32'h0, "low speed ignores pulse");
    pin(1'b1, 4 * 4 * LF + 20);
    check(32'(irq1_latch), 32'h1, "low speed request");
    $display("test low speed done");
    wr(A_MODE, 8'h00);
    pin(1'b0, 2 + 3 * 4 * LF + 20);
    axi_rd(A_STAT, rd, rr);
    accept();
    wr(A_GATE, 8'h3d);
    check(32'(clk_en), 32'h3d, "clock enables");
    pin(1'b1, 20);
    pin(1'b0, 20);
    check(32'(irq1_latch), 32'h0, "gated input silent");
    rdchk(A_STAT, 32'h0, "gated input status");
    $display("test clock gate done");
    @(posedge clk);
    wstrb <= 4'h0;
    wr(A_MASK, 8'h01);
    rdchk(A_MASK, 32'h0, "strobe off ignored");
    wstrb <= 4'h1;
    wr(A_MASK, 8'h01);
    rdchk(A_MASK, 32'h1, "mask set before reset");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    check(32'({clk_en, irq1_latch, irq}), 32'h0, "outputs after second reset");
    rdchk(A_GATE, 32'h0, "gate after second reset");
    rdchk(A_MASK, 32'h0, "mask after second reset");
    $display("test strobe and second reset done");
    final_report();
  end
endmodule // tb_top
